// file: verilog/ahb_pkg.sv
package ahb_pkg;
    // Command byte layout.
    localparam int CMD_SR_BIT      = 7;
    localparam int CMD_FIXED_BIT   = 5;
    localparam int CMD_SINGLE_BIT  = 6;
    localparam int CMD_OP_MSB      = 4;
    // Status byte layout.
    localparam int STS_BUSY_BIT    = 7;
    localparam int STS_EMPTY_BIT   = 6;
    localparam int STS_FULL_BIT    = 5;
    // Stack geometry.
    localparam int STACK_WORDS     = 8;
    localparam int STACK_WIDTH     = 16;
    localparam int BYTE_PTR_W      = 4;
    // Timing: reset hold and modelled execution time.
    localparam int RESET_MIN_CLKS  = 5;
    localparam int CLK_PERIOD_NS   = 8;
    localparam int EXEC_TIME_NS    = 64;
    localparam int EXEC_CYCLES     = (EXEC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_WAIT_NS    = 16;
    localparam int READ_WAIT_CYCLES = (READ_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    // Microsequencer state.
    typedef enum logic [1:0] {
        AHB_IDLE  = 2'b00,
        AHB_FETCH = 2'b01,
        AHB_EXEC  = 2'b10,
        AHB_DONE  = 2'b11
    } ahb_seq_t;
endpackage : ahb_pkg

// file: verilog/ahb_host_if.sv
`timescale 1ns/1ns
// Notes on behaviour
// - Select high: write strobe enters command, read strobe returns status.
// - Select low with read strobe pops one stack byte onto the bus.
// - Select low with write strobe pushes the bus byte onto the stack.
// - Done output low at completion; raised by ack, any access, or reset.
// - Done flag set at completion, cleared on clock while ack is low.
// - Status reads allowed while busy; each access clears the done flag.
// - Service request rises at completion only when command bit is one.
// - Service request enable is command bit 7; low bits choose operation.
// - Service request cleared by low service acknowledge or reset.
// - A later command with service bit zero clears service request.
// - Bus bit 0 is least significant, bit 7 most; high means one.
// - Host pushes low byte first; device pops high byte first.
// - Strobes ignored unless chip select low.
// - Write begins on strobe fall; wait may dip low briefly.
// - Write wait pulse may be zero length.
// - Read lowers wait until data valid, holds data while strobe low.
// - Read clears done after strobe falls; write clears after strobe rises.
// - Operand stack is eight 16-bit words, last in first out.
// - Microsequenced execution with counter, return register, pipeline register.
// - Reset aborts work, clears busy status, resets pointer, keeps command.
module ahb_host_if
    import ahb_pkg::*;
#(
    parameter int EXEC_CLKS = EXEC_CYCLES
) (
    input  wire logic       sys_clk_i,
    input  wire logic       reset_i,
    input  wire logic       chip_sel_n_i,
    input  wire logic       rd_n_i,
    input  wire logic       wr_n_i,
    input  wire logic       cmd_sel_i,
    input  wire logic [7:0] host_data_bus_i,
    output logic      [7:0] host_data_bus_o,
    output logic            host_data_bus_oe_o,
    output logic            wait_n_o,
    output logic            done_n_o,
    output logic            done_n_oe_o,
    output logic            service_request_o,
    input  wire logic       done_ack_n_i,
    input  wire logic       service_ack_n_i
);
    import ahb_pkg::*;

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    // Strobes are asynchronous to the clock; two stages each.
    // Data, select and both acknowledges take the same two stages, so a
    // byte and its select line up with the strobe edge that takes them.
    // The cost is three clocks of latency before any strobe is acted on.
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic [2:0] sync3_r;
    logic       sack1_r, sack2_r, dack1_r, dack2_r;
    logic [7:0] data1_r, data2_r;
    logic       cd1_r, cd2_r;
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            sync1_r <= 3'h7;
            sync2_r <= 3'h7;
            sync3_r <= 3'h7;
            sack1_r <= 1'b1;
            sack2_r <= 1'b1;
            dack1_r <= 1'b1;
            dack2_r <= 1'b1;
            data1_r <= 8'h00;
            data2_r <= 8'h00;
            cd1_r   <= 1'b0;
            cd2_r   <= 1'b0;
        end else begin
            sync1_r <= {chip_sel_n_i, rd_n_i, wr_n_i};
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            sack1_r <= service_ack_n_i;
            sack2_r <= sack1_r;
            dack1_r <= done_ack_n_i;
            dack2_r <= dack1_r;
            data1_r <= host_data_bus_i;
            data2_r <= data1_r;
            cd1_r   <= cmd_sel_i;
            cd2_r   <= cd1_r;
        end
    end

    // ----------------------------------------------------------------
    // Strobe decode
    // ----------------------------------------------------------------
    // Both strobes low is undefined, so it is simply ignored.
    // A third stage on the strobes gives the edge detectors a settled
    // previous level. Only the second and third stages feed logic, which keeps a
    // metastable first stage away from every decision.
    wire cs_ok     = ~sync2_r[2];
    wire rd_lo     = ~sync2_r[1] & sync2_r[0];
    wire wr_lo     = ~sync2_r[0] & sync2_r[1];
    wire rd_fall   = cs_ok & rd_lo & sync3_r[1];
    wire wr_fall   = cs_ok & wr_lo & sync3_r[0];
    wire wr_rise   = cs_ok & sync2_r[0] & ~sync3_r[0];
    wire cmd_wr    = wr_fall & cd2_r;
    wire stat_rd   = rd_fall & cd2_r;
    wire pop_rd    = rd_fall & ~cd2_r;
    wire push_wr   = wr_fall & ~cd2_r;

    // ----------------------------------------------------------------
    // Operand stack, byte addressed inside 16-bit words
    // ----------------------------------------------------------------
    // The byte pointer counts bytes; word = ptr/2, half = ptr[0].
    logic [STACK_WIDTH-1:0] stack_mem [STACK_WORDS];
    logic [BYTE_PTR_W-1:0]  bptr_r;
    wire  [BYTE_PTR_W-1:0]  bptr_dec = bptr_r - 4'h1;
    wire  [2:0]             push_word = bptr_r[3:1];
    wire  [2:0]             pop_word  = bptr_dec[3:1];
    wire                    stk_empty = (bptr_r == 4'h0);
    wire                    stk_full  = (bptr_r == 4'hF);
    // A four-bit byte pointer cannot count sixteen bytes, so full is
    // flagged with one byte still free; a host that trusts it never overruns.
    // Pushes and pops are refused while a command runs, so the stack
    // logic needs the sequencer state declared here.
    ahb_seq_t               seq_r;
    wire                    busy      = (seq_r != AHB_IDLE);
    // Bytes go in low first, so the top byte out is the most significant.
    wire  [7:0] pop_byte = bptr_dec[0] ? stack_mem[pop_word][15:8]
                                       : stack_mem[pop_word][7:0];

    // Overflow wraps and loses old data, as any LIFO would.
    always_ff @(posedge sys_clk_i) begin
        if (push_wr & ~busy) begin
            if (bptr_r[0]) begin
                stack_mem[push_word][15:8] <= data2_r;
            end else begin
                stack_mem[push_word][7:0]  <= data2_r;
            end
        end
    end

    // ----------------------------------------------------------------
    // Microsequencer
    // ----------------------------------------------------------------
    // Counter is loaded from the command opcode; a return register and a
    // pipeline register model the sequenced execution without the maths.
    logic [7:0] cmd_r;
    logic [7:0] upc_r;
    logic [7:0] uret_r;
    logic [7:0] uir_r;
    logic [15:0] cnt_r;
    logic       pend_r;
    wire        complete = (seq_r == AHB_DONE);
    wire [15:0] exec_last = 16'(EXEC_CLKS - 1);

    // The command register keeps its value across reset.
    // A command written while another runs is refused rather than queued,
    // which keeps the microprogram counter load free of any hazard.
    always_ff @(posedge sys_clk_i) begin
        if (cmd_wr & ~busy) begin
            cmd_r <= data2_r;
        end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            seq_r  <= AHB_IDLE;
            upc_r  <= 8'h00;
            uret_r <= 8'h00;
            uir_r  <= 8'h00;
            cnt_r  <= 16'h0000;
            pend_r <= 1'b0;
        end else begin
            unique case (seq_r)
                AHB_IDLE: begin
                    if (cmd_wr) begin
                        seq_r <= AHB_FETCH;
                    end
                end
                AHB_FETCH: begin
                    upc_r  <= {3'h0, cmd_r[CMD_OP_MSB:0]};
                    uret_r <= upc_r;
                    cnt_r  <= 16'h0000;
                    seq_r  <= AHB_EXEC;
                end
                AHB_EXEC: begin
                    uir_r <= upc_r;
                    upc_r <= upc_r + 8'h01;
                    cnt_r <= cnt_r + 16'h0001;
                    if (cnt_r >= exec_last) begin
                        upc_r <= uret_r;
                        seq_r <= AHB_DONE;
                    end
                end
                AHB_DONE: begin
                    seq_r <= AHB_IDLE;
                end
            endcase
            // A command written while busy holds wait low until done.
            // The held wait is the only sign the host gets that it was refused.
            pend_r <= (cmd_wr & busy) | (pend_r & ~complete);
        end
    end

    // ----------------------------------------------------------------
    // Byte pointer, status and completion flags
    // ----------------------------------------------------------------
    // The pointer moves one byte per accepted push or pop. Odd counts from
    // the host leave it mid-word, which the hardware cannot detect.
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            bptr_r <= 4'h0;
        end else if (push_wr & ~busy) begin
            bptr_r <= bptr_r + 4'h1;
        end else if (pop_rd & ~busy) begin
            bptr_r <= bptr_dec;
        end
    end

    // Done flag: set wins over any clear in the same cycle. Continuous
    // polling near completion therefore cannot lose the event here.
    // The pin is open drain: its level copy and its enable are kept in two
    // flops so that both leave the block without any gate in the path.
    logic done_r;
    logic done_n_r;
    wire  done_clr = ~dack2_r | rd_fall | wr_rise;
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            done_r   <= 1'b0;
            done_n_r <= 1'b1;
        end else if (complete) begin
            done_r   <= 1'b1;
            done_n_r <= 1'b0;
        end else if (done_clr) begin
            done_r   <= 1'b0;
            done_n_r <= 1'b1;
        end
    end

    // Holding acknowledge low makes the request unreliable by design.
    // Completion loads the request from the stored command bit, so a later
    // command with the bit clear drops it without any acknowledge.
    // Completion wins over an acknowledge that lands in the same clock.
    logic sreq_r;
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            sreq_r <= 1'b0;
        end else if (complete) begin
            sreq_r <= cmd_r[CMD_SR_BIT];
        end else if (~sack2_r) begin
            sreq_r <= 1'b0;
        end
    end

    // Status bits are packed from the package positions; the low nibble
    // shows the byte pointer so software can check its own byte count.
    wire [7:0] status_byte = STATUS_RESET
                           | (8'(busy) << STS_BUSY_BIT)
                           | (8'(stk_empty) << STS_EMPTY_BIT)
                           | (8'(stk_full) << STS_FULL_BIT)
                           | {4'h0, bptr_r};

    // ----------------------------------------------------------------
    // Bus driver and wait handshake
    // ----------------------------------------------------------------
    // Read data is latched on the strobe fall and held while it stays low.
    // Wait stays low for a fixed count after the fall, and the bus enable
    // rises on the same edge as wait, so the host never samples stale data.
    logic [7:0] dout_r;
    logic       oe_r;
    logic       wait_r;
    logic [3:0] rwait_r;
    wire        rd_held = cs_ok & rd_lo;
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            dout_r  <= 8'h00;
            oe_r    <= 1'b0;
            wait_r  <= 1'b1;
            rwait_r <= 4'h0;
        end else begin
            if (rd_fall) begin
                dout_r  <= cd2_r ? status_byte : pop_byte;
                wait_r  <= 1'b0;
                rwait_r <= 4'(READ_WAIT_CYCLES);
            end else if (rwait_r != 4'h0) begin
                rwait_r <= rwait_r - 4'h1;
                wait_r  <= (rwait_r == 4'h1) | ~rd_held;
            end else begin
                // Writes never lower wait unless a command written while busy is pending.
                wait_r <= ~(pend_r & wr_lo & cs_ok);
            end
            oe_r <= rd_held & (rwait_r <= 4'h1) & ~rd_fall;
        end
    end

    // Every output is a flop copy; none passes through logic on its way out.
    assign host_data_bus_o    = dout_r;
    assign host_data_bus_oe_o = oe_r;
    assign wait_n_o           = wait_r;
    assign done_n_o           = done_n_r;
    assign done_n_oe_o        = done_r;  // Open drain: pulls low when done.
    assign service_request_o  = sreq_r;
endmodule : ahb_host_if

// file: dv/ahb_chk_asserts.sv
`timescale 1ns/1ns
// Watches the host port of the interface block from its pins.
module ahb_chk
    import ahb_pkg::*;
#(
    parameter int EXEC_CLKS = EXEC_CYCLES
) (
    input wire logic       sys_clk_i,
    input wire logic       reset_i,
    input wire logic       chip_sel_n_i,
    input wire logic       rd_n_i,
    input wire logic       wr_n_i,
    input wire logic       cmd_sel_i,
    input wire logic [7:0] host_data_bus_i,
    input wire logic [7:0] host_data_bus_o,
    input wire logic       host_data_bus_oe_o,
    input wire logic       wait_n_o,
    input wire logic       done_n_o,
    input wire logic       done_n_oe_o,
    input wire logic       service_request_o,
    input wire logic       done_ack_n_i,
    input wire logic       service_ack_n_i
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    // Reset is checked while it is held, so this one is never disabled.
    rst_idle_a: assert property (disable iff (1'b0) reset_i |-> wait_n_o
        && !done_n_oe_o && !service_request_o) else $error("Outputs busy in reset.");
    done_low_a: assert property (done_n_oe_o |-> !done_n_o)
        else $error("Done pin not pulled low.");
    // Acknowledges pass two synchroniser stages, so a flag drops two clocks
    // after a low held over two edges has been seen.
    ack_pulse_a: assert property ((done_n_oe_o && !done_ack_n_i) [*2] |->
        ##2 !done_n_oe_o) else $error("Done survived its acknowledge.");
    sreq_ack_a: assert property ((service_request_o && !service_ack_n_i) [*2] |->
        ##2 !service_request_o) else $error("Service request survived acknowledge.");
    sreq_done_a: assert property ($rose(service_request_o) |-> done_n_oe_o)
        else $error("Service request rose apart from done.");
    rd_wait_a: assert property ($fell(wait_n_o) && !rd_n_i |=> !wait_n_o ##1 wait_n_o)
        else $error("Read wait length wrong.");
    oe_valid_a: assert property ($rose(host_data_bus_oe_o) |-> $rose(wait_n_o))
        else $error("Bus driven apart from wait release.");
    oe_drop_a: assert property ($rose(rd_n_i) |-> ##[1:4] !host_data_bus_oe_o)
        else $error("Bus still driven after read.");
    cs_gate_a: assert property (chip_sel_n_i [*4] |-> !$rose(host_data_bus_oe_o))
        else $error("Bus driven while not selected.");
    cover property ($rose(host_data_bus_oe_o));
    cover property ($rose(done_n_oe_o));
    cover property ($rose(service_request_o));
endmodule : ahb_chk

bind ahb_host_if ahb_chk #(.EXEC_CLKS(EXEC_CLKS)) chk_u (.sys_clk_i(sys_clk_i),
    .reset_i(reset_i), .chip_sel_n_i(chip_sel_n_i), .rd_n_i(rd_n_i), .wr_n_i(wr_n_i),
    .cmd_sel_i(cmd_sel_i), .host_data_bus_i(host_data_bus_i),
    .host_data_bus_o(host_data_bus_o), .host_data_bus_oe_o(host_data_bus_oe_o),
    .wait_n_o(wait_n_o), .done_n_o(done_n_o), .done_n_oe_o(done_n_oe_o),
    .service_request_o(service_request_o), .done_ack_n_i(done_ack_n_i),
    .service_ack_n_i(service_ack_n_i));

// file: dv/ahb_host_model.sv
`timescale 1ns/1ns
// Host processor: one strobe at a time, held until the wait line is released.
module ahb_host_model (
    input  wire logic       sys_clk_i,
    input  wire logic       wait_n_i,
    input  wire logic [7:0] bus_i,
    output logic            cs_n_o,
    output logic            rd_n_o,
    output logic            wr_n_o,
    output logic            cmd_sel_o,
    output logic      [7:0] data_o,
    output logic            data_oe_o
);
    // Idle bus: nothing selected, nothing driven.
    initial begin
        {cs_n_o, rd_n_o, wr_n_o, cmd_sel_o, data_oe_o} = 5'h1C;
        data_o = 8'h00;
    end

    // A stuck wait line ends the transfer after a bound so the run cannot hang.
    task automatic xfer(input logic wr, input logic sel, input logic cs,
                        input logic [7:0] d, output logic [7:0] q, output logic ok);
        int n;
        @(posedge sys_clk_i);
        #1;
        {cs_n_o, cmd_sel_o, data_o, data_oe_o} = {~cs, sel, d, wr};
        rd_n_o = wr;
        wr_n_o = ~wr;
        repeat (4) @(posedge sys_clk_i);
        n = 0;
        while (!wait_n_i && n < 60) begin
            @(posedge sys_clk_i);
            n++;
        end
        ok = wait_n_i;
        q = bus_i;
        #1;
        {rd_n_o, wr_n_o, data_oe_o} = 3'b110;
        repeat (3) @(posedge sys_clk_i);
        #1;
        cs_n_o = 1'b1;
    endtask : xfer
endmodule : ahb_host_model

// file: dv/apu_host_bus_interface_bench.sv
`timescale 1ns/1ns
module apu_host_bus_interface_bench;
    import ahb_pkg::*;
    localparam int EXEC_T = 30;
    logic clk = 1'b0, done_ack_n = 1'b1, sack_n = 1'b1;
    logic rst;
    logic [7:0] bus, bus_q, h_d, d_o, q;
    logic cs_n, rd_n, wr_n, sel, h_oe, d_oe, wait_n, done_n, done_oe, sreq, ok;
    logic done_pin;
    logic [15:0] lfsr = 16'h87FC;
    logic [7:0] stk[$];
    int fail_count = 0;
    int tests_run = 0;

    always #4 clk = ~clk;
    // A released bus shows the inverse of its last level, so stale bytes never match.
    always @(posedge clk) bus_q <= bus;
    assign bus = h_oe ? h_d : (d_oe ? d_o : ~bus_q);
    assign done_pin = done_oe ? done_n : 1'b1;

    ahb_host_if #(.EXEC_CLKS(EXEC_T)) dut_u (.sys_clk_i(clk), .reset_i(rst),
        .chip_sel_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n), .cmd_sel_i(sel),
        .host_data_bus_i(bus), .host_data_bus_o(d_o), .host_data_bus_oe_o(d_oe),
        .wait_n_o(wait_n), .done_n_o(done_n), .done_n_oe_o(done_oe),
        .service_request_o(sreq), .done_ack_n_i(done_ack_n), .service_ack_n_i(sack_n));
    ahb_host_model host_u (.sys_clk_i(clk), .wait_n_i(wait_n), .bus_i(bus), .cs_n_o(cs_n),
        .rd_n_o(rd_n), .wr_n_o(wr_n), .cmd_sel_o(sel), .data_o(h_d), .data_oe_o(h_oe));

    function automatic logic [15:0] lfsr_step(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : lfsr_step

    function automatic logic [7:0] stat(input logic busy);
        return {busy, stk.size() == 0, stk.size() == 15, 1'b0, 4'(stk.size())};
    endfunction : stat

    task automatic tally_and_finish;
        $display("Checks run %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp8

    task automatic go(input logic wr, input logic sel, input logic cs, input logic [7:0] d);
        host_u.xfer(wr, sel, cs, d, q, ok);
        if (!ok) begin
            fail_count++;
            tally_and_finish();
        end
    endtask : go

    // Polls the done pin under a bound; completion that never comes fails the run.
    task automatic wait_done;
        int n;
        n = 0;
        while (done_pin !== 1'b0 && n < 200) begin
            @(posedge clk);
            n++;
        end
        if (done_pin !== 1'b0) begin
            fail_count++;
            tally_and_finish();
        end
        #1;
    endtask : wait_done

    task automatic ack(input logic svc);
        @(posedge clk);
        #1;
        {done_ack_n, sack_n} = svc ? 2'b10 : 2'b01;
        repeat (2) @(posedge clk);
        #1;
        // Acknowledges are short pulses, never held low for good.
        {done_ack_n, sack_n} = 2'b11;
        @(posedge clk);
        #1;
    endtask : ack

    // Main sequence: stack traffic, deselected writes that are ignored, then commands and their flags.
    initial begin
        // Reset rises from unknown after time zero, so the design sees a true edge.
        #1;
        rst = 1'b1;
        repeat (RESET_MIN_CLKS) @(posedge clk);
        #1;
        rst = 1'b0;
        cmp8({5'h00, done_pin, sreq, wait_n}, 8'h05);
        go(1'b0, 1'b1, 1'b1, 8'h00);
        cmp8(q, stat(1'b0));
        for (int i = 0; i < 4; i++) begin
            lfsr = lfsr_step(lfsr);
            stk.push_back(lfsr[7:0]);
            go(1'b1, 1'b0, 1'b1, lfsr[7:0]);
        end
        go(1'b1, 1'b0, 1'b0, 8'hA5);
        go(1'b1, 1'b1, 1'b0, 8'h80);
        go(1'b0, 1'b1, 1'b1, 8'h00);
        cmp8(q, stat(1'b0));
        for (int i = 0; i < 4; i++) begin
            go(1'b0, 1'b0, 1'b1, 8'h00);
            cmp8(q, stk.pop_back());
        end
        go(1'b1, 1'b1, 1'b1, 8'h80);
        go(1'b0, 1'b1, 1'b1, 8'h00);
        cmp8(q, stat(1'b1));
        wait_done();
        cmp8({done_pin, sreq}, 8'h01);
        ack(1'b1);
        cmp8({done_pin, sreq}, 8'h00);
        ack(1'b0);
        cmp8({done_pin, sreq}, 8'h02);
        go(1'b1, 1'b1, 1'b1, 8'h80);
        wait_done();
        go(1'b1, 1'b1, 1'b1, 8'h00);
        repeat (2) @(posedge clk);
        #1;
        cmp8({done_pin, sreq}, 8'h03);
        wait_done();
        cmp8({done_pin, sreq}, 8'h00);
        go(1'b0, 1'b1, 1'b1, 8'h00);
        cmp8({7'h00, done_pin}, 8'h01);
        cmp8(q, stat(1'b0));
        // Reset in mid-command: the work is dropped and never completes,
        // the flags go idle and the byte pointer returns to zero.
        lfsr = lfsr_step(lfsr);
        go(1'b1, 1'b0, 1'b1, lfsr[7:0]);
        go(1'b1, 1'b1, 1'b1, 8'h80);
        rst = 1'b1;
        repeat (RESET_MIN_CLKS) @(posedge clk);
        #1;
        rst = 1'b0;
        repeat (EXEC_T + 8) @(posedge clk);
        #1;
        cmp8({6'h00, done_pin, sreq}, 8'h02);
        go(1'b0, 1'b1, 1'b1, 8'h00);
        cmp8(q, stat(1'b0));
        tally_and_finish();
    end
endmodule : apu_host_bus_interface_bench
